// [rtl/rcs_pkg.sv]
// Package: constants for the reset-cause and start-up block
package rcs_pkg;

	// -----------------------------------------------------------------
	// Register map
	// -----------------------------------------------------------------
	localparam logic [1:0] ADDR_BROWNOUT_CTRL = 2'h0;
	localparam logic [1:0] ADDR_RESET_CAUSE   = 2'h1;
	localparam logic [1:0] ADDR_CORE_STATUS   = 2'h2;

	// -----------------------------------------------------------------
	// Cause register bit positions
	// -----------------------------------------------------------------
	localparam int BIT_STACK_OVER  = 7;
	localparam int BIT_STACK_UNDER = 6;
	localparam int BIT_WDT_N       = 4;
	localparam int BIT_PIN_N       = 3;
	localparam int BIT_INSTR_N     = 2;
	localparam int BIT_POR_N       = 1;
	localparam int BIT_BOR_N       = 0;
	localparam logic [7:0] CAUSE_IMPL_MASK = 8'hDF;
	localparam logic [7:0] CAUSE_RESET     = 8'h1C;

	// Status register bit positions
	localparam int BIT_TIMEOUT_N   = 4;
	localparam int BIT_POWERDOWN_N = 3;
	localparam logic [7:0] STATUS_RESET = 8'h18;

	// Brown-out control fields
	localparam int BIT_SW_BOR_EN   = 7;
	localparam int BIT_BOR_FAST    = 6;
	localparam int BIT_BOR_READY   = 0;
	localparam logic [7:0] BORCTRL_RESET = 8'h80;

	// -----------------------------------------------------------------
	// Restart vectors and timing
	// -----------------------------------------------------------------
	localparam logic [14:0] VEC_RESET = 15'h0000;
	localparam logic [14:0] VEC_IRQ   = 15'h0004;
	localparam int START_DELAY_CYC    = 10;
	localparam int CLK_HZ             = 20_000_000;
	localparam int PWRT_MS            = 64;
	localparam int PWRT_CYC           = (CLK_HZ / 1000) * PWRT_MS;

	typedef enum logic [2:0] {
		RCS_HOLD,
		RCS_PWRT,
		RCS_WAIT_PIN,
		RCS_DELAY,
		RCS_RUN
	} rcs_state_e;

endpackage : rcs_pkg

// [rtl/rcs_delay_if.sv]
// Interface: start-delay counter request and done
`timescale 1ns/1ps
interface rcs_delay_if;
	logic start;
	logic busy;
	logic done;
	modport ctrl (output start, input busy, input done);
	modport cnt  (input start, output busy, output done);
endinterface : rcs_delay_if

// [rtl/rcs_counter.sv]
// Down counter for timed waits
`timescale 1ns/1ps
module rcs_counter #(
	parameter int CYCLES = 10
) (
	input  wire logic  ref_clk_in,
	input  wire logic  srst_in,
	rcs_delay_if.cnt   dly
);
	localparam int W = $clog2(CYCLES + 1);

	logic [W-1:0] cnt_q;

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			cnt_q <= '0;
		end else if (dly.start) begin
			cnt_q <= W'(CYCLES);
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - W'(1);
		end
	end

	assign dly.busy = (cnt_q != '0);
	assign dly.done = (cnt_q == W'(1));

endmodule : rcs_counter

// [rtl/rcs_reset_cause.sv]
// Start-up sequencer and reset-cause flag registers
`timescale 1ns/1ps

// Behaviour
// RULE_01: Run only after timer and pin release
// RULE_02: Power-up timer ignores the reset pin
// RULE_03: Run ten cycles after late pin release
// RULE_04: Every reset updates flags; vector zero
// RULE_05: Power-on sets status, presets cause flags
// RULE_06: Stack overflow flag at bit seven
// RULE_07: Stack underflow flag at bit six
// RULE_08: Stack resets only when enabled
// RULE_09: Watchdog reset clears flag and timeout
// RULE_10: Pin reset clears pin flag
// RULE_11: Reset instruction clears its flag
// RULE_12: Power-on clears power-on flag
// RULE_13: Power-on or brown-out clears brown-out flag
// RULE_14: Brown-out presets flags and status
// RULE_15: Pin reset in sleep adjusts status
// RULE_16: Watchdog wake clears both status bits
// RULE_17: Interrupt wake continues, may vector
// RULE_18: Bit five reads zero
// RULE_19: Pin enabled by config or programming
// RULE_20: Power-up timer only when selected
// RULE_21: Hardware update beats firmware write
// RULE_22: Flags kept across unrelated resets
module rcs_reset_cause #(
	parameter int PWRT_CYCLES = rcs_pkg::PWRT_CYC
) (
	input  wire logic        ref_clk_in,
	input  wire logic        srst_in,
	input  wire logic        por_event_in,
	input  wire logic        bor_event_in,
	input  wire logic        bor_ready_in,
	input  wire logic        ext_reset_pin_in,
	input  wire logic        wdt_timeout_in,
	input  wire logic        reset_instr_in,
	input  wire logic        stack_over_in,
	input  wire logic        stack_under_in,
	input  wire logic        irq_wake_in,
	input  wire logic        sleep_enter_in,
	input  wire logic        global_irq_en_in,
	input  wire logic [14:0] pc_in,
	input  wire logic        stack_fault_reset_en_in,
	input  wire logic        pin_reset_cfg_in,
	input  wire logic        low_volt_prog_cfg_in,
	input  wire logic        powerup_timer_cfg_n_in,
	input  wire logic [1:0]  addr_in,
	input  wire logic [7:0]  wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [7:0]  rdata_out,
	output logic             core_run_out,
	output logic             core_reset_out,
	output logic             pc_load_out,
	output logic      [14:0] pc_vector_out,
	output logic             irq_vector_pending_out,
	output logic             pin_input_out
);

	// -----------------------------------------------------------------
	// Event decode
	// -----------------------------------------------------------------
	logic pin_en;
	logic pin_rst;
	logic stk_ovf_rst;
	logic stk_unf_rst;
	logic wdt_rst;
	logic wdt_wake;
	logic any_full_reset;
	logic sleeping_q;
	logic pin_q;

	assign pin_en       = pin_reset_cfg_in | low_volt_prog_cfg_in;               // [RULE_19]
	assign pin_input_out = ext_reset_pin_in;
	assign pin_rst      = pin_en & pin_q & ~ext_reset_pin_in & ~por_event_in & ~bor_event_in; // [RULE_10]
	assign stk_ovf_rst  = stack_over_in & stack_fault_reset_en_in;                // [RULE_08]
	assign stk_unf_rst  = stack_under_in & stack_fault_reset_en_in;               // [RULE_08]
	assign wdt_rst      = wdt_timeout_in & ~sleeping_q;
	assign wdt_wake     = wdt_timeout_in & sleeping_q;
	assign any_full_reset = por_event_in | bor_event_in | pin_rst | wdt_rst
		| reset_instr_in | stk_ovf_rst | stk_unf_rst;                          // [RULE_04]

	// -----------------------------------------------------------------
	// Pin edge
	// -----------------------------------------------------------------
	// Pin reset is taken on the falling edge only: a held pin is a
	// start-up hold and must not restart the sequencer every cycle.
	// Cleared low, so a pin held from power-up gives no false edge.
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= ext_reset_pin_in;
		end
	end

	// -----------------------------------------------------------------
	// Start-up sequencer
	// -----------------------------------------------------------------
	localparam int PW = $clog2(PWRT_CYCLES + 1);

	rcs_pkg::rcs_state_e state_q;
	logic [PW-1:0]       pwrt_q;
	logic                pwrt_active_q;
	rcs_delay_if         dly ();

	rcs_counter #(
		.CYCLES (rcs_pkg::START_DELAY_CYC)
	) u_delay (
		.ref_clk_in (ref_clk_in),
		.srst_in    (srst_in),
		.dly        (dly)
	);

	// Timer runs regardless of the pin so it can expire while pin held
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			pwrt_q        <= '0;
			pwrt_active_q <= 1'b0;
		end else if (por_event_in | bor_event_in) begin
			pwrt_q        <= powerup_timer_cfg_n_in ? '0 : PW'(PWRT_CYCLES);      // [RULE_20]
			pwrt_active_q <= ~powerup_timer_cfg_n_in;
		end else if (pwrt_q != '0) begin
			pwrt_q <= pwrt_q - PW'(1);                                          // [RULE_02]
		end else begin
			pwrt_active_q <= 1'b0;
		end
	end

	logic pin_held;
	assign pin_held = pin_en & ~ext_reset_pin_in;
	assign dly.start = (state_q == rcs_pkg::RCS_WAIT_PIN) & ~pin_held;

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			state_q <= rcs_pkg::RCS_HOLD;
		end else if (any_full_reset) begin
			state_q <= rcs_pkg::RCS_HOLD;
		end else begin
			unique case (state_q)
				rcs_pkg::RCS_HOLD: begin
					state_q <= rcs_pkg::RCS_PWRT;
				end
				rcs_pkg::RCS_PWRT: begin
					if (!pwrt_active_q) begin
						state_q <= rcs_pkg::RCS_WAIT_PIN;                   // [RULE_01]
					end
				end
				rcs_pkg::RCS_WAIT_PIN: begin
					if (!pin_held) begin
						state_q <= rcs_pkg::RCS_DELAY;                      // [RULE_03]
					end
				end
				rcs_pkg::RCS_DELAY: begin
					// Lost count: wait for the pin again rather than hang
					if (!dly.busy) begin
						state_q <= rcs_pkg::RCS_WAIT_PIN;
					end
					if (dly.done) begin
						state_q <= rcs_pkg::RCS_RUN;                        // [RULE_03]
					end
				end
				rcs_pkg::RCS_RUN: begin
					state_q <= rcs_pkg::RCS_RUN;
				end
			endcase
		end
	end

	assign core_run_out   = (state_q == rcs_pkg::RCS_RUN);
	assign core_reset_out = ~core_run_out;

	// -----------------------------------------------------------------
	// Sleep tracking
	// -----------------------------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			sleeping_q <= 1'b0;
		end else if (any_full_reset | wdt_wake | irq_wake_in) begin
			sleeping_q <= 1'b0;
		end else if (sleep_enter_in & core_run_out) begin
			sleeping_q <= 1'b1;
		end
	end

	// -----------------------------------------------------------------
	// Restart vector
	// -----------------------------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			pc_load_out            <= 1'b0;
			pc_vector_out          <= rcs_pkg::VEC_RESET;
			irq_vector_pending_out <= 1'b0;
		end else if (any_full_reset) begin
			pc_load_out            <= 1'b1;
			pc_vector_out          <= rcs_pkg::VEC_RESET;                       // [RULE_04] [RULE_11]
			irq_vector_pending_out <= 1'b0;
		end else if (wdt_wake) begin
			pc_load_out            <= 1'b1;
			pc_vector_out          <= pc_in + 15'h0001;                         // [RULE_16]
			irq_vector_pending_out <= 1'b0;
		end else if (irq_wake_in & sleeping_q) begin
			pc_load_out            <= 1'b1;
			pc_vector_out          <= pc_in + 15'h0001;                         // [RULE_17]
			irq_vector_pending_out <= global_irq_en_in;                         // [RULE_17]
		end else begin
			pc_load_out            <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// Cause flags; hardware events override firmware writes
	// -----------------------------------------------------------------
	logic [7:0] cause_q;
	logic [7:0] cause_d;
	logic [7:0] status_q;
	logic [7:0] status_d;
	logic [7:0] borctl_q;
	logic       wr_cause;
	logic       wr_status;
	logic       wr_borctl;

	// Write select, shared by all three register write paths
	function automatic logic reg_hit(input logic wr, input logic [1:0] a, input logic [1:0] r);
		return wr & (a == r);
	endfunction : reg_hit

	assign wr_cause  = reg_hit(wr_in, addr_in, rcs_pkg::ADDR_RESET_CAUSE);
	assign wr_status = reg_hit(wr_in, addr_in, rcs_pkg::ADDR_CORE_STATUS);
	assign wr_borctl = reg_hit(wr_in, addr_in, rcs_pkg::ADDR_BROWNOUT_CTRL);

	// Only flags a reset names are touched; others survive the reset
	always_comb begin
		cause_d = cause_q;                                                     // [RULE_22]
		if (wr_cause) begin
			cause_d = wdata_in & rcs_pkg::CAUSE_IMPL_MASK;
		end
		if (por_event_in) begin
			cause_d[rcs_pkg::BIT_STACK_OVER]  = 1'b0;                          // [RULE_05]
			cause_d[rcs_pkg::BIT_STACK_UNDER] = 1'b0;
			cause_d[rcs_pkg::BIT_WDT_N]       = 1'b1;
			cause_d[rcs_pkg::BIT_PIN_N]       = 1'b1;
			cause_d[rcs_pkg::BIT_INSTR_N]     = 1'b1;
			cause_d[rcs_pkg::BIT_POR_N]       = 1'b0;                          // [RULE_12]
			cause_d[rcs_pkg::BIT_BOR_N]       = 1'b0;                          // [RULE_13]
		end else if (bor_event_in) begin
			cause_d[rcs_pkg::BIT_STACK_OVER]  = 1'b0;                          // [RULE_14]
			cause_d[rcs_pkg::BIT_STACK_UNDER] = 1'b0;
			cause_d[rcs_pkg::BIT_PIN_N]       = 1'b1;
			cause_d[rcs_pkg::BIT_INSTR_N]     = 1'b1;
			cause_d[rcs_pkg::BIT_BOR_N]       = 1'b0;                          // [RULE_13]
		end else begin
			if (stk_ovf_rst) begin
				cause_d[rcs_pkg::BIT_STACK_OVER] = 1'b1;                       // [RULE_06] [RULE_21]
			end
			if (stk_unf_rst) begin
				cause_d[rcs_pkg::BIT_STACK_UNDER] = 1'b1;                      // [RULE_07] [RULE_21]
			end
			if (wdt_rst) begin
				cause_d[rcs_pkg::BIT_WDT_N] = 1'b0;                            // [RULE_09] [RULE_21]
			end
			if (pin_rst) begin
				cause_d[rcs_pkg::BIT_PIN_N] = 1'b0;                            // [RULE_10] [RULE_21]
			end
			if (reset_instr_in) begin
				cause_d[rcs_pkg::BIT_INSTR_N] = 1'b0;                          // [RULE_11] [RULE_21]
			end
		end
		cause_d[5] = 1'b0;                                                     // [RULE_18]
	end

	always_comb begin
		status_d = status_q;
		if (wr_status) begin
			status_d[2:0] = wdata_in[2:0];
		end
		if (por_event_in | bor_event_in) begin
			status_d[rcs_pkg::BIT_TIMEOUT_N]   = 1'b1;                         // [RULE_05] [RULE_14]
			status_d[rcs_pkg::BIT_POWERDOWN_N] = 1'b1;
			if (por_event_in) begin
				status_d[2:0] = 3'h0;
			end
		end else if (wdt_rst) begin
			status_d[rcs_pkg::BIT_TIMEOUT_N] = 1'b0;                           // [RULE_09]
		end else if (wdt_wake) begin
			status_d[rcs_pkg::BIT_TIMEOUT_N]   = 1'b0;                         // [RULE_16]
			status_d[rcs_pkg::BIT_POWERDOWN_N] = 1'b0;
		end else if ((pin_rst | irq_wake_in) & sleeping_q) begin
			status_d[rcs_pkg::BIT_TIMEOUT_N]   = 1'b1;                         // [RULE_15] [RULE_17]
			status_d[rcs_pkg::BIT_POWERDOWN_N] = 1'b0;
		end else if (sleep_enter_in & core_run_out) begin
			status_d[rcs_pkg::BIT_TIMEOUT_N]   = 1'b1;
			status_d[rcs_pkg::BIT_POWERDOWN_N] = 1'b0;
		end
		status_d[7:5] = 3'h0;
	end

	// Flags deliberately ignore srst_in values beyond power-on defaults
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			cause_q  <= rcs_pkg::CAUSE_RESET;
			status_q <= rcs_pkg::STATUS_RESET;
		end else begin
			cause_q  <= cause_d;
			status_q <= status_d;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			borctl_q <= rcs_pkg::BORCTRL_RESET;
		end else if (wr_borctl) begin
			borctl_q[rcs_pkg::BIT_SW_BOR_EN] <= wdata_in[rcs_pkg::BIT_SW_BOR_EN];
			borctl_q[rcs_pkg::BIT_BOR_FAST]  <= wdata_in[rcs_pkg::BIT_BOR_FAST];
		end
	end

	// -----------------------------------------------------------------
	// Read port: data one cycle after the strobe
	// -----------------------------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			rdata_out <= 8'h00;
		end else if (rd_in) begin
			unique case (addr_in)
				rcs_pkg::ADDR_BROWNOUT_CTRL: begin
					rdata_out <= {borctl_q[7:6], 5'h00, bor_ready_in};
				end
				rcs_pkg::ADDR_RESET_CAUSE: begin
					rdata_out <= cause_q & rcs_pkg::CAUSE_IMPL_MASK;            // [RULE_18]
				end
				rcs_pkg::ADDR_CORE_STATUS: begin
					rdata_out <= status_q;
				end
				default: begin
					rdata_out <= 8'h00;
				end
			endcase
		end else begin
			rdata_out <= 8'h00;
		end
	end

endmodule : rcs_reset_cause

// [sim/rcs_monitor.sv]
// Checker: port relations of the reset-cause block
`timescale 1ns/1ps
module rcs_monitor #(
	parameter int PWRT_CYCLES = 20
) (
	input wire logic        ref_clk_in,
	input wire logic        srst_in,
	input wire logic        por_event_in,
	input wire logic        bor_event_in,
	input wire logic        ext_reset_pin_in,
	input wire logic        wdt_timeout_in,
	input wire logic        reset_instr_in,
	input wire logic        stack_over_in,
	input wire logic        stack_under_in,
	input wire logic        stack_fault_reset_en_in,
	input wire logic        pin_reset_cfg_in,
	input wire logic        low_volt_prog_cfg_in,
	input wire logic [1:0]  addr_in,
	input wire logic        rd_in,
	input wire logic [7:0]  rdata_out,
	input wire logic        core_run_out,
	input wire logic        pc_load_out,
	input wire logic [14:0] pc_vector_out,
	input wire logic        pin_input_out
);
	// ----
	// Helpers
	// ----
	wire pin_en = pin_reset_cfg_in | low_volt_prog_cfg_in;
	wire quiet  = !(por_event_in | bor_event_in | wdt_timeout_in | reset_instr_in | stack_under_in);

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (srst_in);

	a_pin_mirror: assert property (pin_input_out == ext_reset_pin_in)
		else $error("pin mirror differs");
	a_pin_hold: assert property (pin_en && !ext_reset_pin_in |=> !core_run_out)
		else $error("running with pin held");
	a_start_delay: assert property ($rose(ext_reset_pin_in) && pin_en && !core_run_out
		|-> ##1 !core_run_out[*8] ##1 !core_run_out[*2] ##1 core_run_out)
		else $error("start delay wrong");
	a_bit5_zero: assert property (rdata_out[5] == 1'b0)
		else $error("bit five set");
	a_read_idle: assert property (!rd_in || addr_in == 2'h3 |=> rdata_out == 8'h00)
		else $error("read data not zero");
	a_stack_gate: assert property (!stack_fault_reset_en_in && stack_over_in && core_run_out && quiet
		&& ext_reset_pin_in |=> core_run_out)
		else $error("stack fault reset while disabled");
	a_stack_reset: assert property (stack_fault_reset_en_in && stack_over_in && core_run_out |=> !core_run_out)
		else $error("stack fault reset missing");
	a_instr_vector: assert property (reset_instr_in
		|-> ##[1:4] (pc_load_out && pc_vector_out == rcs_pkg::VEC_RESET))
		else $error("reset vector missing");
	a_power_stop: assert property (por_event_in || bor_event_in |=> !core_run_out)
		else $error("running after power event");
endmodule : rcs_monitor

// [sim/rcs_src_model.sv]
// Model: reset sources and the board's reset pin
`timescale 1ns/1ps
module rcs_src_model (
	input  wire logic       ref_clk_in,
	output logic      [7:0] ev_out,
	output logic            pin_out
);
	// Board holds the pin low until released
	initial begin
		ev_out = 8'h00;
		pin_out = 1'b0;
	end

	task fire(input int k);
		@(posedge ref_clk_in);
		ev_out[k] <= 1'b1;
		@(posedge ref_clk_in);
		ev_out[k] <= 1'b0;
	endtask : fire

	task set_pin(input logic lvl);
		@(posedge ref_clk_in);
		pin_out <= lvl;
	endtask : set_pin
endmodule : rcs_src_model

// [sim/tb_top.sv]
// Testbench: start-up, register port and every reset kind
`timescale 1ns/1ps
module tb_top;
	localparam int PWRT_CYCLES = 20;
	localparam logic [1:0] A_CAUSE = rcs_pkg::ADDR_RESET_CAUSE;
	localparam logic [1:0] A_STAT = rcs_pkg::ADDR_CORE_STATUS;
	logic        ref_clk_in, srst_in, por_event_in, bor_event_in, bor_ready_in, ext_reset_pin_in;
	logic        wdt_timeout_in, reset_instr_in, stack_over_in, stack_under_in, irq_wake_in;
	logic        sleep_enter_in, global_irq_en_in, stack_fault_reset_en_in, pin_reset_cfg_in;
	logic        low_volt_prog_cfg_in, powerup_timer_cfg_n_in, wr_in, rd_in;
	logic        core_run_out, core_reset_out, pc_load_out, irq_vector_pending_out, pin_input_out;
	logic [14:0] pc_in, pc_vector_out;
	logic [1:0]  addr_in;
	logic [7:0]  wdata_in, rdata_out, v, st;
	int          fails, compares, seed, i, k;
	int          order [6] = '{4, 5, 2, 3, 1, 0};

	rcs_reset_cause #(.PWRT_CYCLES(PWRT_CYCLES)) i_dut (.*);
	rcs_src_model i_src (.ref_clk_in(ref_clk_in), .pin_out(ext_reset_pin_in), .ev_out({sleep_enter_in,
		irq_wake_in, stack_under_in, stack_over_in, reset_instr_in, wdt_timeout_in, bor_event_in, por_event_in}));

	initial begin
		ref_clk_in = 1'b0;
		forever #25 ref_clk_in = ~ref_clk_in;
	end

	// ----
	// Checking and bus tasks
	// ----
	function logic [7:0] nxt(input logic [7:0] c, input int e);
		case (e)
			0: return 8'h1C;
			1: return {3'b000, c[4], 2'b11, c[1], 1'b0};
			2: return c & 8'hEF;
			3: return c & 8'hFB;
			4: return c | 8'h80;
			default: return c | 8'h40;
		endcase
	endfunction : nxt

	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		compares++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task wr_reg(input logic [1:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge ref_clk_in);
		wr_in <= 1'b0;
	endtask : wr_reg

	task rd_chk(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
		@(posedge ref_clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge ref_clk_in);
		rd_in <= 1'b0;
		#1 chk(n, rdata_out & m, e);
	endtask : rd_chk

	// Load pulse lasts one cycle, so poll every cycle
	task wait_load(input logic [14:0] e, input string n);
		#1;
		for (i = 0; i < 20 && pc_load_out !== 1'b1; i++) @(posedge ref_clk_in) #1;
		chk(n, {pc_load_out, pc_vector_out}, {1'b1, e});
	endtask : wait_load

	task end_sim;
		$display("fails %0d compares %0d", fails, compares);
		if (fails == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim

	initial begin
		#(50 * 3000);
		fails++;
		end_sim();
	end

	// ----
	// Main sequence
	// ----
	initial begin
		seed = 32'h4fa5;
		{srst_in, pin_reset_cfg_in} = 2'b11;
		{low_volt_prog_cfg_in, powerup_timer_cfg_n_in, wr_in, rd_in} = 4'h0;
		{global_irq_en_in, stack_fault_reset_en_in, addr_in, wdata_in} = 12'h000;
		bor_ready_in = 1'($random(seed));
		pc_in = 15'($random(seed));
		repeat (6) @(posedge ref_clk_in);
		srst_in <= 1'b0;
		rd_chk(A_CAUSE, 8'hFF, 8'h1C, "cause_rst");
		rd_chk(A_STAT, 8'hF8, 8'h18, "status_rst");
		rd_chk(rcs_pkg::ADDR_BROWNOUT_CTRL, 8'hFF, {7'h40, bor_ready_in}, "borctl_rst");
		wr_reg(A_CAUSE, 8'hFF);
		i_src.fire(0);
		repeat (2 * PWRT_CYCLES) @(posedge ref_clk_in);
		#1 chk("run_held", core_run_out, 1'b0);
		i_src.set_pin(1'b1);
		repeat (10) @(posedge ref_clk_in);
		#1 chk("run_early", core_run_out, 1'b0);
		@(posedge ref_clk_in);
		#1 chk("run_start", core_run_out, 1'b1);
		rd_chk(A_CAUSE, 8'hFF, 8'h1C, "cause_por");
		rd_chk(A_STAT, 8'h18, 8'h18, "status_por");
		$display("startup done");
		for (k = 0; k < 6; k++) begin
			v = 8'($random(seed));
			wr_reg(A_CAUSE, v);
			bor_ready_in <= v[7];
			rd_chk(A_CAUSE, 8'hFF, v & 8'hDF, "cause_rw");
			wr_reg(A_STAT, v);
			rd_chk(A_STAT, 8'hE7, v & 8'h07, "status_rw");
			rd_chk(2'h3, 8'hFF, 8'h00, "unmapped");
			wr_reg(rcs_pkg::ADDR_BROWNOUT_CTRL, v);
			rd_chk(rcs_pkg::ADDR_BROWNOUT_CTRL, 8'hFF, {v[7:6], 5'h00, v[7]}, "borctl_rw");
		end
		$display("registers done");
		i_src.fire(4);
		repeat (3) @(posedge ref_clk_in);
		#1 chk("stk_off_run", core_run_out, 1'b1);
		rd_chk(A_CAUSE, 8'hFF, v & 8'hDF, "stk_off_cause");
		global_irq_en_in <= 1'b1;
		pc_in <= 15'($random(seed));
		i_src.fire(7);
		i_src.fire(2);
		wait_load(pc_in + 15'h0001, "wdt_wake_pc");
		rd_chk(A_STAT, 8'h18, 8'h00, "wdt_wake_st");
		rd_chk(A_CAUSE, 8'hFF, v & 8'hDF, "wdt_wake_cause");
		pc_in <= 15'($random(seed));
		i_src.fire(7);
		i_src.fire(6);
		wait_load(pc_in + 15'h0001, "irq_wake_pc");
		for (i = 0; i < 8 && irq_vector_pending_out !== 1'b1; i++) @(posedge ref_clk_in) #1;
		chk("irq_pending", irq_vector_pending_out, 1'b1);
		rd_chk(A_STAT, 8'h18, 8'h10, "irq_wake_st");
		$display("wake done");
		st = 8'h10;
		stack_fault_reset_en_in <= 1'b1;
		foreach (order[j]) begin
			for (i = 0; i < 60 && core_run_out !== 1'b1; i++) @(posedge ref_clk_in);
			v = 8'($random(seed)) & 8'hDF;
			wr_reg(A_CAUSE, v);
			i_src.fire(order[j]);
			wait_load(rcs_pkg::VEC_RESET, "reset_pc");
			st = (order[j] < 2) ? 8'h18 : (order[j] == 2) ? (st & 8'h08) : st;
			rd_chk(A_CAUSE, 8'hFF, nxt(v, order[j]), "cause_evt");
			rd_chk(A_STAT, 8'h18, st, "status_evt");
		end
		$display("resets done");
		for (i = 0; i < 60 && core_run_out !== 1'b1; i++) @(posedge ref_clk_in);
		i_src.set_pin(1'b0);
		repeat (3) @(posedge ref_clk_in);
		#1 chk("pin_run", {core_run_out, core_reset_out, pin_input_out}, 3'b010);
		rd_chk(A_CAUSE, 8'hFF, 8'h14, "pin_cause");
		rd_chk(A_STAT, 8'h18, 8'h18, "pin_status");
		$display("pin reset done");
		@(posedge ref_clk_in);
		low_volt_prog_cfg_in <= 1'b1;
		pin_reset_cfg_in <= 1'b0;
		repeat (15) @(posedge ref_clk_in);
		#1 chk("lvp_hold", core_run_out, 1'b0);
		@(posedge ref_clk_in);
		{low_volt_prog_cfg_in, powerup_timer_cfg_n_in} <= 2'b01;
		repeat (10) @(posedge ref_clk_in);
		#1 chk("pin_off_wait", core_run_out, 1'b0);
		@(posedge ref_clk_in);
		#1 chk("pin_off_run", core_run_out, 1'b1);
		i_src.fire(0);
		repeat (12) @(posedge ref_clk_in);
		#1 chk("pwrt_off_wait", core_run_out, 1'b0);
		@(posedge ref_clk_in);
		#1 chk("pwrt_off_run", core_run_out, 1'b1);
		i_src.set_pin(1'b1);
		pin_reset_cfg_in <= 1'b1;
		i_src.fire(7);
		i_src.set_pin(1'b0);
		wait_load(rcs_pkg::VEC_RESET, "sleep_pin_pc");
		rd_chk(A_CAUSE, 8'hFF, 8'h14, "sleep_pin_cause");
		rd_chk(A_STAT, 8'h18, 8'h10, "sleep_pin_st");
		$display("config done");
		end_sim();
	end
endmodule : tb_top

bind rcs_reset_cause rcs_monitor #(.PWRT_CYCLES(PWRT_CYCLES)) i_mon (.*);
